// *** rtl/acs_map.vh ***
// Register map, field positions, reset values and timing counts
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// Register byte offsets
`define ACS_OFF_CTRL0      8'h00
`define ACS_OFF_CTRL1      8'h04
`define ACS_OFF_CTRL2      8'h08
`define ACS_OFF_CTRL3      8'h0c
`define ACS_OFF_CTRL4      8'h10
`define ACS_OFF_RES_BASE   8'h20
`define ACS_RES_IDX_HI     4
`define ACS_RES_IDX_LO     2

// conv_control_0 fields
`define ACS_C0_CH_LO       0
`define ACS_C0_CH_HI       2
`define ACS_C0_MODE_LO     3
`define ACS_C0_MODE_HI     4
`define ACS_C0_TRG         5
`define ACS_C0_START       6

// conv_control_1 fields
`define ACS_C1_SWP_LO      0
`define ACS_C1_SWP_HI      1
`define ACS_C1_PRIO        2
`define ACS_C1_RES10       3
`define ACS_C1_EXT_LO      6
`define ACS_C1_EXT_HI      7

// conv_control_2 fields
`define ACS_C2_SMP         0
`define ACS_C2_GRP_LO      1
`define ACS_C2_GRP_HI      2
`define ACS_C2_HWSEL       5

// conv_control_3 and conv_control_4 fields
`define ACS_C3_DMA         0
`define ACS_C3_MP          1
`define ACS_C3_STAT_LO     3
`define ACS_C3_STAT_HI     4
`define ACS_C4_G2_LO       0
`define ACS_C4_G2_HI       1

// Operating mode codes
`define ACS_MODE_ONESHOT   2'h0
`define ACS_MODE_REPEAT    2'h1
`define ACS_MODE_SWEEP     2'h2
`define ACS_MODE_RSWEEP    2'h3

// Extended input codes
`define ACS_EXT_NONE       2'h0
`define ACS_EXT_IN0        2'h1
`define ACS_EXT_IN1        2'h2

// Converter cycles per channel
`define ACS_CYC_8B         8'd49
`define ACS_CYC_10B        8'd59
`define ACS_CYC_8B_SH      8'd28
`define ACS_CYC_10B_SH     8'd33

// Reset values
`define ACS_RST_CTRL       8'h00

`endif

// *** rtl/acs_sequencer.v ***
// Conversion sequencer for a multi-channel SAR converter with APB registers
//
// Notes on behaviour
// - Single-conversion mode with multi-port off converts the selected input once per start.
// - Single and repeat modes select group channel or an extended input.
// - Software trigger: conversion begins when the start flag is written one.
// - External trigger: falling edge starts conversion once start flag set.
// - Hardware trigger: motor timer event starts conversion once flag set.
// - Single modes with software trigger clear the start flag on finish, except single-conversion with multi-port set.
// - Writing zero to the start flag stops conversion in every mode.
// - Repeat mode converts the one selected input until stopped.
// - Single sweep converts selected inputs lowest first, then stops.
// - Sweep set is first two, four, six or eight group channels.
// - Repeat sweep 0 repeats the sweep set until flag cleared.
// - Repeat sweep 1 interleaves priority channels between the others.
// - Repeat sweep 1 ignores triggers during a conversion.
// - Multi-port converts base group eight channels, then second group.
// - Multi-port single sweep converts sixteen inputs once, then stops.
// - Multi-port repeat sweep repeats sixteen inputs until flag cleared.
// - Without DMA, repeating modes raise no interrupt request.
// - Without DMA, single sweep raises one request at sweep end.
// - With DMA, every channel conversion raises a request.
// - Without DMA, result goes to register of the converted channel.
// - With DMA, every result goes to result register zero.
// - Mode field: 00 single, 01 repeat, 10 sweep, 11 repeat sweep.
// - Priority select bit picks repeat sweep 1 over repeat sweep 0.
// - Outside repeat sweep 1 a trigger mid-conversion aborts and restarts.
// - Channel takes 49/59 cycles, or 28/33 with sample-and-hold.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
`include "acs_map.vh"

module acs_sequencer #(
  parameter ADDR_W = 8,
  parameter AD_DIV = 8'd1
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata_ff,
  output reg               pready_ff,
  output reg               pslverr_ff,
  input  wire              external_trigger_n,
  input  wire              motor_timer_counter,
  input  wire [9:0]        conv_data,
  output reg  [1:0]        mux_group_ff,
  output reg  [2:0]        mux_channel_ff,
  output reg  [1:0]        mux_ext_ff,
  output reg               busy_ff,
  output reg               done_ff,
  output reg               irq_ff
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam [7:0] RES_BASE = `ACS_OFF_RES_BASE;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  reg  [2:0]  chan_sel_ff;
  reg  [1:0]  op_mode_ff;
  reg         trig_src_ff;
  reg         start_ff;
  reg  [1:0]  sweep_sel_ff;
  reg         prio_sweep_ff;
  reg         res10_ff;
  reg  [1:0]  ext_sel_ff;
  reg         samp_hold_ff;
  reg  [1:0]  grp_sel_ff;
  reg         hw_cause_ff;
  reg         dma_en_ff;
  reg         mp_en_ff;
  reg  [1:0]  grp2_sel_ff;
  reg  [9:0]  res_mem [0:7];

  // Sequencer state
  reg  [1:0]  state_ff;
  reg  [3:0]  idx_ff;
  reg  [1:0]  prio_ptr_ff;
  reg  [2:0]  rest_ptr_ff;
  reg         prio_turn_ff;
  reg  [15:0] cnt_ff;
  reg  [1:0]  trg_sync_ff;
  reg         trg_q_ff;

  reg  [1:0]  nxt_state;
  reg  [3:0]  nxt_idx;
  reg  [1:0]  nxt_prio_ptr;
  reg  [2:0]  nxt_rest_ptr;
  reg         nxt_prio_turn;
  reg  [15:0] nxt_cnt;
  reg         nxt_start;
  reg         nxt_done;
  reg         nxt_irq;
  reg  [1:0]  cur_grp;
  reg  [2:0]  cur_ch;
  reg  [1:0]  cur_ext;
  reg  [2:0]  res_idx;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire        apb_setup = psel & penable & ~pready_ff;
  wire        apb_wr    = psel & penable & pready_ff & pwrite;
  wire [7:0]  addr8     = paddr[7:0];
  wire        hit_res   = (addr8[7:5] == RES_BASE[7:5]) &
                          (addr8[1:0] == 2'h0);
  wire [2:0]  rd_idx    = addr8[`ACS_RES_IDX_HI:`ACS_RES_IDX_LO];
  wire        wr_c0     = apb_wr & (addr8 == `ACS_OFF_CTRL0);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire m_single = ~mp_en_ff & (op_mode_ff == `ACS_MODE_ONESHOT);
  wire m_repeat = ~mp_en_ff & (op_mode_ff == `ACS_MODE_REPEAT);
  wire m_sweep  = ~mp_en_ff & (op_mode_ff == `ACS_MODE_SWEEP);
  wire m_rsw    = ~mp_en_ff & (op_mode_ff == `ACS_MODE_RSWEEP);
  wire m_rsw1   = m_rsw & prio_sweep_ff;
  wire m_mp     = mp_en_ff & op_mode_ff[1];
  wire mp_once  = m_mp & ~op_mode_ff[0];
  wire one_pin  = m_single | m_repeat | (mp_en_ff & ~op_mode_ff[1]);
  wire [2:0] prio_cnt  = {1'b0, sweep_sel_ff} + 3'h1;
  wire [3:0] sweep_end = {1'b0, sweep_sel_ff, 1'b1};
  wire [3:0] last_idx  = m_mp ? 4'hf : sweep_end;
  wire       seq_last  = one_pin | (idx_ff == last_idx);
  wire       once_mode = m_single | m_sweep | mp_once;

  // Converter cycle count per channel
  wire [7:0] base_cyc = samp_hold_ff ?
                        (res10_ff ? `ACS_CYC_10B_SH : `ACS_CYC_8B_SH) :
                        (res10_ff ? `ACS_CYC_10B : `ACS_CYC_8B);
  wire [15:0] cyc_prod = {8'h00, base_cyc} * {8'h00, AD_DIV};
  wire [15:0] cnt_load = cyc_prod - 16'h1;

  ////////////////////////////////////////////////////////////////////////////
  // External trigger synchroniser and edge detect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_sync_ff <= 2'h3;
      trg_q_ff    <= 1'b1;
    end else begin
      trg_sync_ff <= {trg_sync_ff[0], external_trigger_n};
      trg_q_ff    <= trg_sync_ff[1];
    end
  end

  wire ext_fall = trg_q_ff & ~trg_sync_ff[1];
  wire trig_evt = trig_src_ff &
                  (hw_cause_ff ? motor_timer_counter : ext_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Current input selection
  always @* begin
    cur_grp = grp_sel_ff;
    cur_ch  = chan_sel_ff;
    cur_ext = `ACS_EXT_NONE;
    res_idx = chan_sel_ff;
    if (one_pin) begin
      cur_ext = ext_sel_ff;
      if (ext_sel_ff == `ACS_EXT_IN0)
        res_idx = 3'h0;
      else if (ext_sel_ff == `ACS_EXT_IN1)
        res_idx = 3'h1;
    end else if (m_mp) begin
      cur_grp = idx_ff[3] ? grp2_sel_ff : 2'h0;
      cur_ch  = idx_ff[2:0];
      res_idx = idx_ff[2:0];
    end else if (m_rsw1) begin
      cur_ch  = prio_turn_ff ? {1'b0, prio_ptr_ff} : rest_ptr_ff;
      res_idx = cur_ch;
    end else begin
      cur_ch  = idx_ff[2:0];
      res_idx = idx_ff[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    nxt_state     = state_ff;
    nxt_idx       = idx_ff;
    nxt_prio_ptr  = prio_ptr_ff;
    nxt_rest_ptr  = rest_ptr_ff;
    nxt_prio_turn = prio_turn_ff;
    nxt_cnt       = cnt_ff;
    nxt_done      = 1'b0;
    nxt_irq       = 1'b0;
    nxt_start     = start_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_ff) begin
          nxt_state = trig_src_ff ? ST_WAIT : ST_CONV;
        end
        nxt_idx       = 4'h0;
        nxt_prio_ptr  = 2'h0;
        nxt_rest_ptr  = prio_cnt;
        nxt_prio_turn = 1'b1;
        nxt_cnt       = cnt_load;
      end
      ST_WAIT: begin
        nxt_idx       = 4'h0;
        nxt_prio_ptr  = 2'h0;
        nxt_rest_ptr  = prio_cnt;
        nxt_prio_turn = 1'b1;
        nxt_cnt       = cnt_load;
        if (trig_evt) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (trig_evt && !m_rsw1) begin
          nxt_idx       = 4'h0;
          nxt_prio_ptr  = 2'h0;
          nxt_rest_ptr  = prio_cnt;
          nxt_prio_turn = 1'b1;
          nxt_cnt       = cnt_load;
        end else if (cnt_ff != 16'h0) begin
          nxt_cnt = cnt_ff - 16'h1;
        end else begin
          nxt_done = 1'b1;
          nxt_cnt  = cnt_load;
          nxt_irq  = dma_en_ff |
                     m_single |
                     ((m_sweep | mp_once) & seq_last);
          if (once_mode && seq_last) begin
            nxt_idx = 4'h0;
            if (!trig_src_ff) begin
              nxt_start = 1'b0;
              nxt_state = ST_IDLE;
            end else begin
              nxt_state = ST_WAIT;
            end
          end else if (m_rsw1) begin
            if (prio_turn_ff) begin
              nxt_prio_ptr = (({1'b0, prio_ptr_ff} + 3'h1) == prio_cnt) ?
                             2'h0 : prio_ptr_ff + 2'h1;
            end else begin
              nxt_rest_ptr = (rest_ptr_ff == 3'h7) ?
                             prio_cnt : rest_ptr_ff + 3'h1;
            end
            nxt_prio_turn = ~prio_turn_ff;
          end else if (seq_last) begin
            nxt_idx = 4'h0;
          end else begin
            nxt_idx = idx_ff + 4'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (!start_ff) begin
      nxt_state = ST_IDLE;
    end
    if (wr_c0) begin
      nxt_start = pwdata[`ACS_C0_START];
      if (!pwdata[`ACS_C0_START]) begin
        nxt_state = ST_IDLE;
        nxt_done  = 1'b0;
        nxt_irq   = 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff       <= ST_IDLE;
      idx_ff         <= 4'h0;
      prio_ptr_ff    <= 2'h0;
      rest_ptr_ff    <= 3'h1;
      prio_turn_ff   <= 1'b1;
      cnt_ff         <= 16'h0;
      start_ff       <= 1'b0;
      done_ff        <= 1'b0;
      irq_ff         <= 1'b0;
      busy_ff        <= 1'b0;
      mux_group_ff   <= 2'h0;
      mux_channel_ff <= 3'h0;
      mux_ext_ff     <= 2'h0;
    end else begin
      state_ff       <= nxt_state;
      idx_ff         <= nxt_idx;
      prio_ptr_ff    <= nxt_prio_ptr;
      rest_ptr_ff    <= nxt_rest_ptr;
      prio_turn_ff   <= nxt_prio_turn;
      cnt_ff         <= nxt_cnt;
      start_ff       <= nxt_start;
      done_ff        <= nxt_done;
      irq_ff         <= nxt_irq;
      busy_ff        <= (nxt_state == ST_CONV);
      mux_group_ff   <= cur_grp;
      mux_channel_ff <= cur_ch;
      mux_ext_ff     <= cur_ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers
  wire       res_wr  = (state_ff == ST_CONV) & nxt_done;
  wire [2:0] res_dst = dma_en_ff ? 3'h0 : res_idx;
  wire [9:0] res_val = res10_ff ? conv_data : {2'h0, conv_data[7:0]};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_res
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          res_mem[gi] <= 10'h000;
        end else if (res_wr && res_dst == gi) begin
          res_mem[gi] <= res_val;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Configuration writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_sel_ff   <= 3'h0;
      op_mode_ff    <= 2'h0;
      trig_src_ff   <= 1'b0;
      sweep_sel_ff  <= 2'h0;
      prio_sweep_ff <= 1'b0;
      res10_ff      <= 1'b0;
      ext_sel_ff    <= 2'h0;
      samp_hold_ff  <= 1'b0;
      grp_sel_ff    <= 2'h0;
      hw_cause_ff   <= 1'b0;
      dma_en_ff     <= 1'b0;
      mp_en_ff      <= 1'b0;
      grp2_sel_ff   <= 2'h0;
    end else if (apb_wr) begin
      case (addr8)
        `ACS_OFF_CTRL0: begin
          chan_sel_ff <= pwdata[`ACS_C0_CH_HI:`ACS_C0_CH_LO];
          op_mode_ff  <= pwdata[`ACS_C0_MODE_HI:`ACS_C0_MODE_LO];
          trig_src_ff <= pwdata[`ACS_C0_TRG];
        end
        `ACS_OFF_CTRL1: begin
          sweep_sel_ff  <= pwdata[`ACS_C1_SWP_HI:`ACS_C1_SWP_LO];
          prio_sweep_ff <= pwdata[`ACS_C1_PRIO];
          res10_ff      <= pwdata[`ACS_C1_RES10];
          ext_sel_ff    <= pwdata[`ACS_C1_EXT_HI:`ACS_C1_EXT_LO];
        end
        `ACS_OFF_CTRL2: begin
          samp_hold_ff <= pwdata[`ACS_C2_SMP];
          grp_sel_ff   <= pwdata[`ACS_C2_GRP_HI:`ACS_C2_GRP_LO];
          hw_cause_ff  <= pwdata[`ACS_C2_HWSEL];
        end
        `ACS_OFF_CTRL3: begin
          dma_en_ff <= pwdata[`ACS_C3_DMA];
          mp_en_ff  <= pwdata[`ACS_C3_MP];
        end
        `ACS_OFF_CTRL4: begin
          grp2_sel_ff <= pwdata[`ACS_C4_G2_HI:`ACS_C4_G2_LO];
        end
        default: begin
          grp2_sel_ff <= grp2_sel_ff;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and answer
  always @* begin
    nxt_rdata = 32'h0;
    nxt_err   = 1'b0;
    case (addr8)
      `ACS_OFF_CTRL0: begin
        nxt_rdata[`ACS_C0_CH_HI:`ACS_C0_CH_LO]     = chan_sel_ff;
        nxt_rdata[`ACS_C0_MODE_HI:`ACS_C0_MODE_LO] = op_mode_ff;
        nxt_rdata[`ACS_C0_TRG]                     = trig_src_ff;
        nxt_rdata[`ACS_C0_START]                   = start_ff;
      end
      `ACS_OFF_CTRL1: begin
        nxt_rdata[`ACS_C1_SWP_HI:`ACS_C1_SWP_LO] = sweep_sel_ff;
        nxt_rdata[`ACS_C1_PRIO]                  = prio_sweep_ff;
        nxt_rdata[`ACS_C1_RES10]                 = res10_ff;
        nxt_rdata[`ACS_C1_EXT_HI:`ACS_C1_EXT_LO] = ext_sel_ff;
      end
      `ACS_OFF_CTRL2: begin
        nxt_rdata[`ACS_C2_SMP]                   = samp_hold_ff;
        nxt_rdata[`ACS_C2_GRP_HI:`ACS_C2_GRP_LO] = grp_sel_ff;
        nxt_rdata[`ACS_C2_HWSEL]                 = hw_cause_ff;
      end
      `ACS_OFF_CTRL3: begin
        nxt_rdata[`ACS_C3_DMA] = dma_en_ff;
        nxt_rdata[`ACS_C3_MP]  = mp_en_ff;
        nxt_rdata[`ACS_C3_STAT_HI:`ACS_C3_STAT_LO] =
          mp_en_ff ? mux_group_ff : 2'h0;
      end
      `ACS_OFF_CTRL4: begin
        nxt_rdata[`ACS_C4_G2_HI:`ACS_C4_G2_LO] = grp2_sel_ff;
      end
      default: begin
        if (hit_res) begin
          nxt_rdata[9:0] = res_mem[rd_idx];
        end else begin
          nxt_err = 1'b1;
        end
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & nxt_err;
      if (apb_setup && !pwrite) begin
        prdata_ff <= nxt_rdata;
      end else begin
        prdata_ff <= 32'h0;
      end
    end
  end

endmodule

// *** test/acs_far_model.sv ***
// Far-side model: analog inputs and trigger sources
`timescale 1ns/10ps
module acs_far_model (
  input  wire       pclk,
  input  wire       busy_ff,
  input  wire [1:0] mux_group_ff,
  input  wire [2:0] mux_channel_ff,
  input  wire [1:0] mux_ext_ff,
  output wire [9:0] conv_data,
  output reg        external_trigger_n,
  output reg        motor_timer_counter
);
  wire [9:0] level;
  // Voltage encodes selection; inverted while nothing converts
  assign level = {mux_group_ff, mux_ext_ff, 3'h5, mux_channel_ff};
  assign conv_data = busy_ff ? level : ~level;
  initial begin
    external_trigger_n = 1'b1;
    motor_timer_counter = 1'b0;
  end
  task ext_fire;
    begin
      @(posedge pclk);
      external_trigger_n <= 1'b0;
      repeat (4) @(posedge pclk);
      external_trigger_n <= 1'b1;
    end
  endtask
  task hw_fire;
    begin
      @(posedge pclk);
      motor_timer_counter <= 1'b1;
      @(posedge pclk);
      motor_timer_counter <= 1'b0;
    end
  endtask
endmodule

// *** test/acs_seq_assertions.sv ***
// Port-level checks for the conversion sequencer
`timescale 1ns/10ps
module acs_seq_assertions #(
  parameter ADDR_W = 8,
  parameter AD_DIV = 8'd1
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata_ff,
  input wire        pready_ff,
  input wire        pslverr_ff,
  input wire        busy_ff,
  input wire        done_ff,
  input wire        irq_ff
);
  localparam int MIN_RUN = 27 * AD_DIV;
  reg  [15:0] run_cnt_ff;
  wire [15:0] nxt_run_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since conversion start or last completion
  assign nxt_run_cnt = (done_ff || !busy_ff) ? 16'h0000
                                             : run_cnt_ff + 16'h0001;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      run_cnt_ff <= 16'h0000;
    else
      run_cnt_ff <= nxt_run_cnt;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready_ff)
    else $error("pready late after access");
  a_ready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("prdata not zero outside answer");
  a_irq_with_done: assert property (irq_ff |-> done_ff)
    else $error("irq without completion");
  a_done_pulse: assert property (done_ff |=> !done_ff)
    else $error("completion strobe too long");
  a_done_in_conv: assert property (done_ff |-> $past(busy_ff))
    else $error("completion without conversion");
  a_conv_min_len: assert property (done_ff |-> run_cnt_ff >= MIN_RUN)
    else $error("conversion too short");
  a_conv_bounded: assert property
    ($rose(busy_ff) |-> ##[1:200] (done_ff || !busy_ff))
    else $error("conversion never completes");
endmodule
////////////////////////////////////////////////////////////////////////////
bind acs_sequencer acs_seq_assertions #(.ADDR_W(ADDR_W), .AD_DIV(AD_DIV))
  i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
         .prdata_ff(prdata_ff), .pready_ff(pready_ff),
         .pslverr_ff(pslverr_ff), .busy_ff(busy_ff), .done_ff(done_ff),
         .irq_ff(irq_ff));

// *** test/acs_sequencer_tb.sv ***
// Testbench for the conversion sequencer
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_sequencer_tb;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdat;
  reg         serr;
  wire [31:0] prdata_ff;
  wire        pready_ff, pslverr_ff, ext_n, motor, busy_ff, done_ff, irq_ff;
  wire [9:0]  conv_data;
  wire [1:0]  mux_group_ff, mux_ext_ff;
  wire [2:0]  mux_channel_ff;
  reg  [4:0]  cur_ff;
  reg  [4:0]  seq [0:31];
  integer     n_done, n_irq, waited, err_total, n_checks, s, j;
  integer     cyc, last_done, gap;

  acs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .external_trigger_n(ext_n), .motor_timer_counter(motor),
    .conv_data(conv_data), .mux_group_ff(mux_group_ff),
    .mux_channel_ff(mux_channel_ff), .mux_ext_ff(mux_ext_ff),
    .busy_ff(busy_ff), .done_ff(done_ff), .irq_ff(irq_ff));
  acs_far_model i_pm (.pclk(pclk), .busy_ff(busy_ff),
    .mux_group_ff(mux_group_ff), .mux_channel_ff(mux_channel_ff),
    .mux_ext_ff(mux_ext_ff), .conv_data(conv_data),
    .external_trigger_n(ext_n), .motor_timer_counter(motor));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Channel under conversion, logged at each completion
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (done_ff === 1'b1) begin
      gap       <= cyc - last_done;
      last_done <= cyc;
    end
    if (busy_ff && !done_ff)
      cur_ff <= {mux_group_ff, mux_channel_ff};
    if (done_ff === 1'b1 && n_done < 32) begin
      seq[n_done] <= cur_ff;
      n_done <= n_done + 1;
    end
    if (irq_ff === 1'b1)
      n_irq <= n_irq + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task test_done;
    begin
      $display("Checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task cmp(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("Error %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready_ff !== 1'b1 && n < 20);
      rdat = prdata_ff;
      serr = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready_ff !== 1'b1) begin
        err_total = err_total + 1;
        $display("Error pready exp 1 got 0");
        test_done;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [8*10:1] nm, input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      cmp(nm, e, rdat);
    end
  endtask
  task wait_done(input integer k);
    begin
      waited = 0;
      while (n_done < k && waited < 2000) begin
        @(posedge pclk);
        waited = waited + 1;
      end
      if (n_done < k) begin
        err_total = err_total + 1;
        $display("Error done_count exp %0d got %0d", k, n_done);
        test_done;
      end
    end
  endtask
  task go(input [31:0] c0, input integer k);
    begin
      n_done = 0;
      n_irq = 0;
      wr(`ACS_OFF_CTRL0, c0);
      wait_done(k);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {n_done, n_irq, err_total, n_checks, cyc, last_done, gap} = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (s = 0; s < 5; s = s + 1)
      rdc("ctrl_rst", `ACS_OFF_CTRL0 + 4 * s, `ACS_RST_CTRL);
    rdc("res_rst", `ACS_OFF_RES_BASE, 32'h0);
    wr(8'h40, 32'hff);
    cmp("slverr", 1, serr);
    wr(`ACS_OFF_RES_BASE + 4, 32'h3ff);
    rdc("res_ro", `ACS_OFF_RES_BASE + 4, 32'h0);
    $display("Test registers end");
    wr(`ACS_OFF_CTRL2, 32'h04);
    wr(`ACS_OFF_CTRL1, 32'h08);
    go(32'h45, 1);
    rdc("res5", `ACS_OFF_RES_BASE + 20, 32'h22d);
    rdc("start_clr", `ACS_OFF_CTRL0, 32'h05);
    repeat (100) @(posedge pclk);
    cmp("once", 1, n_done);
    cmp("irq_once", 1, n_irq);
    wr(`ACS_OFF_CTRL2, 32'h0);
    wr(`ACS_OFF_CTRL1, 32'h40);
    go(32'h40, 1);
    rdc("ext_res", `ACS_OFF_RES_BASE, 32'h68);
    $display("Test one-shot end");
    for (s = 0; s < 4; s = s + 1) begin
      wr(`ACS_OFF_CTRL1, s);
      go(32'h50, 2 * s + 2);
      repeat (100) @(posedge pclk);
      cmp("sweep_len", 2 * s + 2, n_done);
      cmp("sweep_irq", 1, n_irq);
      for (j = 0; j < 2 * s + 2; j = j + 1)
        cmp("sweep_ch", j, seq[j]);
    end
    for (j = 0; j < 8; j = j + 1)
      rdc("res_j", `ACS_OFF_RES_BASE + 4 * j, 32'h28 + j);
    wr(`ACS_OFF_CTRL3, 32'h1);
    wr(`ACS_OFF_CTRL1, 32'h0);
    go(32'h50, 2);
    repeat (5) @(posedge pclk);
    cmp("dma_irq", 2, n_irq);
    wr(`ACS_OFF_CTRL3, 32'h0);
    rdc("dma_res", `ACS_OFF_RES_BASE, 32'h29);
    $display("Test sweep end");
    go(32'h4a, 3);
    for (j = 0; j < 3; j = j + 1)
      cmp("rep_ch", 2, seq[j]);
    cmp("rep_irq", 0, n_irq);
    cmp("cyc_8b", `ACS_CYC_8B, gap);
    wr(`ACS_OFF_CTRL0, 32'h0a);
    repeat (3) @(posedge pclk);
    cmp("busy_stop", 0, busy_ff);
    n_done = 0;
    repeat (100) @(posedge pclk);
    cmp("no_more", 0, n_done);
    wr(`ACS_OFF_CTRL2, 32'h01);
    go(32'h4a, 2);
    cmp("cyc_8b_sh", `ACS_CYC_8B_SH, gap);
    wr(`ACS_OFF_CTRL0, 32'h0a);
    wr(`ACS_OFF_CTRL1, 32'h08);
    go(32'h4a, 2);
    cmp("cyc_10b_sh", `ACS_CYC_10B_SH, gap);
    wr(`ACS_OFF_CTRL0, 32'h0a);
    wr(`ACS_OFF_CTRL2, 32'h00);
    go(32'h4a, 2);
    cmp("cyc_10b", `ACS_CYC_10B, gap);
    wr(`ACS_OFF_CTRL0, 32'h0a);
    wr(`ACS_OFF_CTRL1, 32'h00);
    $display("Test repeat end");
    go(32'h61, 0);
    repeat (30) @(posedge pclk);
    cmp("trg_wait", 0, busy_ff);
    i_pm.ext_fire;
    wait_done(1);
    rdc("flag_kept", `ACS_OFF_CTRL0, 32'h61);
    wr(`ACS_OFF_CTRL0, 32'h0);
    wr(`ACS_OFF_CTRL2, 32'h20);
    go(32'h61, 0);
    i_pm.hw_fire;
    repeat (20) @(posedge pclk);
    i_pm.hw_fire;
    wait_done(1);
    cmp("restart", 1, waited >= 40);
    wr(`ACS_OFF_CTRL0, 32'h0);
    wr(`ACS_OFF_CTRL2, 32'h0);
    $display("Test triggers end");
    go(32'h58, 5);
    for (j = 0; j < 5; j = j + 1)
      cmp("rs0_ch", j % 2, seq[j]);
    cmp("rs0_irq", 0, n_irq);
    wr(`ACS_OFF_CTRL0, 32'h0);
    wr(`ACS_OFF_CTRL1, 32'h04);
    go(32'h78, 0);
    i_pm.ext_fire;
    repeat (15) @(posedge pclk);
    i_pm.ext_fire;
    wait_done(1);
    cmp("ignore", 1, waited < 40);
    wait_done(6);
    for (j = 0; j < 6; j = j + 1)
      cmp("rs1_ch", (j % 2) ? (j + 1) / 2 : 0, seq[j]);
    wr(`ACS_OFF_CTRL0, 32'h0);
    $display("Test repeat sweep end");
    wr(`ACS_OFF_CTRL3, 32'h3);
    wr(`ACS_OFF_CTRL4, 32'h3);
    wr(`ACS_OFF_CTRL1, 32'h3);
    go(32'h50, 16);
    repeat (100) @(posedge pclk);
    cmp("mp_once", 16, n_done);
    cmp("mp_irq", 16, n_irq);
    go(32'h58, 17);
    for (j = 0; j < 17; j = j + 1)
      cmp("mp_ch", (j < 8) ? j : ((j < 16) ? j + 16 : 0), seq[j]);
    wr(`ACS_OFF_CTRL0, 32'h0);
    wr(`ACS_OFF_CTRL3, 32'h0);
    $display("Test multi-port end");
    test_done;
  end
endmodule
